// ---- design/irqc_edge.sv ----
// Per-bit rising and falling edge detector on synchronous inputs.
// Assumes inputs already synchronous to clk.
`timescale 1ns/1ns
module irqc_edge #(
	parameter int unsigned W = 1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);

	logic [W-1:0] prev_r;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_r <= '0;
		end else if (ce) begin
			prev_r <= d;
		end
	end

	for (genvar i = 0; i < W; i++) begin : g_bit
		assign rise[i] = ce & d[i] & ~prev_r[i];
		assign fall[i] = ce & ~d[i] & prev_r[i];
	end

endmodule : irqc_edge

// ---- design/irqc_phase.sv ----
// Four-phase sequencer marking the clock phases of an instruction cycle.
// Assumes the core shares this phase count.
`timescale 1ns/1ns
module irqc_phase
	import irqc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	output irqc_phase_t phase_r
);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_r <= PH_FIRST;
		end else if (ce) begin
			case (phase_r)
				PH_FIRST: phase_r <= PH_SECOND;
				PH_SECOND: phase_r <= PH_THIRD;
				PH_THIRD: phase_r <= PH_FOURTH;
				PH_FOURTH: phase_r <= PH_FIRST;
				default: phase_r <= PH_FIRST;
			endcase
		end
	end

endmodule : irqc_phase

// ---- design/irqc_pkg.sv ----
// Constants, types and register map of the interrupt request controller.
// Assumes a 125 MHz clock with four clock phases to one instruction cycle.
package irqc_pkg;

	localparam int unsigned ADDR_W = 3;
	localparam int unsigned PC_W = 13;

	// Register offsets on the plain register port
	localparam logic [ADDR_W-1:0] OFF_CTL = 3'h0;
	localparam logic [ADDR_W-1:0] OFF_PCM = 3'h1;
	localparam logic [ADDR_W-1:0] OFF_PFL = 3'h2;
	localparam logic [ADDR_W-1:0] OFF_PEN = 3'h3;
	localparam logic [ADDR_W-1:0] OFF_CFG = 3'h4;

	// Bits of interrupt_control_status
	localparam int unsigned B_GLOBAL_EN = 7;
	localparam int unsigned B_PERIPH_EN = 6;
	localparam int unsigned B_T0_EN = 5;
	localparam int unsigned B_PIN_EN = 4;
	localparam int unsigned B_CHG_EN = 3;
	localparam int unsigned B_T0_FLAG = 2;
	localparam int unsigned B_PIN_FLAG = 1;
	localparam int unsigned B_CHG_FLAG = 0;
	// Bit of the configuration register
	localparam int unsigned B_EDGE = 0;

	localparam logic [7:0] CTL_RST = 8'h00;
	localparam logic [7:0] PCM_RST = 8'h00;
	localparam logic [7:0] PFL_RST = 8'h00;
	localparam logic [7:0] PEN_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] PFL_IMPL = 8'hFD;
	localparam logic [7:0] CFG_IMPL = 8'h01;
	localparam logic [7:0] RD_NONE = 8'h00;

	localparam logic [PC_W-1:0] VECTOR = 13'h0004;
	localparam logic [7:0] T0_MAX = 8'hFF;
	localparam logic [7:0] T0_MIN = 8'h00;

	// Latency in instruction cycles, and in clocks
	localparam int unsigned PHASES = 4;
	localparam int unsigned LAT_TCY = 3;
	localparam int unsigned LAT_CYC = LAT_TCY * PHASES;
	localparam int unsigned LCNT_W = $clog2(LAT_CYC);

	typedef enum logic [1:0] {PH_FIRST, PH_SECOND, PH_THIRD, PH_FOURTH} irqc_phase_t;
	typedef enum logic {LS_IDLE, LS_ARMED} irqc_lat_t;

	typedef struct packed {
		logic take;
		logic [PC_W-1:0] addr;
	} irqc_vec_t;

endpackage : irqc_pkg

// ---- design/irqc_top.sv ----
// Interrupt request controller: flags, enables, latency and vectoring.
// Assumes a core that pushes the PC when vec_r.take pulses and runs
// return_from_handler as a one-cycle strobe; inputs are synchronous.
//
// Operation
// - Global enable set lets enabled interrupts in; clear blocks all.
// - Every reset clears the global enable.
// - Return-from-handler sets the global enable again.
// - Servicing clears global enable, pushes return address, vectors to 0004h.
// - Event-to-vector latency three to four instruction cycles.
// - Flags set by their events whatever the enables say.
// - Clearing global enable cancels an interrupt due next; it stays pending.
// - External pin edge polarity follows the edge-select bit.
// - Valid external edge sets its flag; its enable masks it.
// - Enabled pending flag wakes the core whatever the global enable.
// - Timer-0 rollover FFh to 00h sets its flag; its enable gates it.
// - Masked port pin change sets the port-change flag.
// - Change during a port read at second phase start may be missed.
// - Requests are sampled at first phase of each instruction cycle.
// - Control register: enables bits 7 to 3, flags bits 2 to 0.
// - Peripheral flags and enables share bit positions in two registers.
// - Each individual enable masks only its own source.
// - Only the return address is saved on entry.
`timescale 1ns/1ns
module irqc_top
	import irqc_pkg::*;
#(
	parameter int unsigned PORT_W = 6
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_r,
	input wire logic external_interrupt_pin,
	input wire logic [PORT_W-1:0] port_pins,
	input wire logic port_read,
	input wire logic [7:0] timer0_count,
	input wire logic [7:0] periph_evt,
	input wire logic return_from_handler,
	output logic irq_req,
	output logic wake,
	output irqc_vec_t vec_r
);

	if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
		$error("PORT_W must be 1 to 8");
	end

	localparam logic [7:0] PCM_IMPL = 8'((1 << PORT_W) - 1);

	function automatic logic hit(
		input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off,
		input logic strobe
	);
		return strobe && (a == off);
	endfunction : hit

	logic [7:0] ctl_r;
	logic [7:0] pcm_r;
	logic [7:0] pfl_r;
	logic [7:0] pen_r;
	logic [7:0] cfg_r;
	logic [7:0] t0_prev_r;
	irqc_phase_t phase_r;
	irqc_lat_t lat_st_r;
	logic [LCNT_W-1:0] lat_cnt_r;
	logic ext_rise;
	logic ext_fall;
	logic [PORT_W-1:0] port_rise;
	logic [PORT_W-1:0] port_fall;
	logic [PORT_W-1:0] port_chg;
	logic ext_evt;
	logic port_evt;
	logic t0_evt;
	logic [7:0] per_evt;
	logic ph_first;
	logic ph_second;
	logic wr_ctl;
	logic ge_clr_now;
	logic main_hit;
	logic per_hit;
	logic pend;
	logic take_nxt;

	irqc_phase u_phase (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.phase_r(phase_r)
	);

	irqc_edge #(.W(1)) u_ext_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.d(external_interrupt_pin),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	irqc_edge #(.W(PORT_W)) u_port_edge (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.d(port_pins),
		.rise(port_rise),
		.fall(port_fall)
	);

	assign ph_first = (phase_r == PH_FIRST);
	assign ph_second = (phase_r == PH_SECOND);
	assign wr_ctl = hit(reg_addr, OFF_CTL, reg_wr);
	assign ge_clr_now = wr_ctl && !reg_wdata[B_GLOBAL_EN];

	// Event detection
	assign ext_evt = cfg_r[B_EDGE] ? ext_rise : ext_fall;
	assign port_chg = port_rise | port_fall;
	// A read at the start of the second phase masks a coincident change
	assign port_evt = |(port_chg & pcm_r[PORT_W-1:0]) && !(port_read && ph_second);
	assign t0_evt = ce && (t0_prev_r == T0_MAX) && (timer0_count == T0_MIN);
	assign per_evt = ce ? (periph_evt & PFL_IMPL) : 8'h00;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			t0_prev_r <= T0_MIN;
		end else if (ce) begin
			t0_prev_r <= timer0_count;
		end
	end

	// Main control register; later assignments win
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_r <= CTL_RST;
		end else if (ce) begin
			if (wr_ctl) begin
				ctl_r <= reg_wdata;
			end
			if (take_nxt) begin
				ctl_r[B_GLOBAL_EN] <= 1'b0;
			end else if (return_from_handler) begin
				ctl_r[B_GLOBAL_EN] <= 1'b1;
			end
			// Hardware set beats a same-cycle software clear
			if (t0_evt) begin
				ctl_r[B_T0_FLAG] <= 1'b1;
			end
			if (ext_evt) begin
				ctl_r[B_PIN_FLAG] <= 1'b1;
			end
			if (port_evt) begin
				ctl_r[B_CHG_FLAG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pcm_r <= PCM_RST;
		end else if (ce && hit(reg_addr, OFF_PCM, reg_wr)) begin
			pcm_r <= reg_wdata & PCM_IMPL;
		end
	end

	// Peripheral flags, set wins over clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pfl_r <= PFL_RST;
		end else if (ce) begin
			if (hit(reg_addr, OFF_PFL, reg_wr)) begin
				pfl_r <= (reg_wdata & PFL_IMPL) | per_evt;
			end else begin
				pfl_r <= pfl_r | per_evt;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pen_r <= PEN_RST;
		end else if (ce && hit(reg_addr, OFF_PEN, reg_wr)) begin
			pen_r <= reg_wdata & PFL_IMPL;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_r <= CFG_RST;
		end else if (ce && hit(reg_addr, OFF_CFG, reg_wr)) begin
			cfg_r <= reg_wdata & CFG_IMPL;
		end
	end

	// Request combination
	assign main_hit = |(ctl_r[B_T0_EN:B_CHG_EN] & ctl_r[B_T0_FLAG:B_CHG_FLAG]);
	assign per_hit = ctl_r[B_PERIPH_EN] && |(pfl_r & pen_r);
	assign pend = main_hit || per_hit;
	assign irq_req = ctl_r[B_GLOBAL_EN] && pend;
	assign wake = pend;

	// Latency sequencer: armed at first phase, vectors three cycles later
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lat_st_r <= LS_IDLE;
			lat_cnt_r <= '0;
		end else if (ce) begin
			case (lat_st_r)
				LS_IDLE: begin
					if (ph_first && irq_req) begin
						lat_st_r <= LS_ARMED;
						lat_cnt_r <= LCNT_W'(LAT_CYC - 1);
					end
				end
				LS_ARMED: begin
					if (!irq_req || ge_clr_now || lat_cnt_r == '0) begin
						lat_st_r <= LS_IDLE;
					end else begin
						lat_cnt_r <= lat_cnt_r - 1'b1;
					end
				end
				default: lat_st_r <= LS_IDLE;
			endcase
		end
	end

	assign take_nxt = ce && lat_st_r == LS_ARMED && lat_cnt_r == '0 && irq_req && !ge_clr_now;

	// Vector strobe carries only the target; the core pushes its PC
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			vec_r <= '0;
		end else if (ce) begin
			vec_r.take <= take_nxt;
			if (take_nxt) begin
				vec_r.addr <= VECTOR;
			end
		end
	end

	// Read port, data in the following cycle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata_r <= RD_NONE;
		end else if (ce) begin
			reg_rdata_r <= RD_NONE;
			if (reg_rd) begin
				case (reg_addr)
					OFF_CTL: reg_rdata_r <= ctl_r;
					OFF_PCM: reg_rdata_r <= pcm_r;
					OFF_PFL: reg_rdata_r <= pfl_r;
					OFF_PEN: reg_rdata_r <= pen_r;
					OFF_CFG: reg_rdata_r <= cfg_r;
					default: reg_rdata_r <= RD_NONE;
				endcase
			end
		end
	end

	// Checks
	sequence s_arm;
		ph_first && irq_req && lat_st_r == LS_IDLE;
	endsequence

	sequence s_vectored;
		vec_r.take && !ctl_r[B_GLOBAL_EN] && vec_r.addr == VECTOR;
	endsequence

	property p_genable_reset;
		@(posedge clk) disable iff (sys_rst)
		$past(sys_rst) |-> !ctl_r[B_GLOBAL_EN];
	endproperty
	a_genable_reset: assert property (p_genable_reset) else $error("global enable set after reset");

	property p_take_needs_genable;
		@(posedge clk) disable iff (sys_rst || !ce)
		$rose(vec_r.take) |-> $past(ctl_r[B_GLOBAL_EN]);
	endproperty
	a_take_needs_genable: assert property (p_take_needs_genable) else $error("vector taken with enable clear");

	property p_vector;
		@(posedge clk) disable iff (sys_rst || !ce)
		$rose(vec_r.take) |-> s_vectored;
	endproperty
	a_vector: assert property (p_vector) else $error("bad vector entry");

	property p_return;
		@(posedge clk) disable iff (sys_rst || !ce)
		return_from_handler && !ctl_r[B_GLOBAL_EN] |=> ctl_r[B_GLOBAL_EN];
	endproperty
	a_return: assert property (p_return) else $error("return did not re-enable");

	property p_latency;
		@(posedge clk) disable iff (sys_rst || !ce)
		s_arm |-> ##[1:13] (vec_r.take || !irq_req);
	endproperty
	a_latency: assert property (p_latency) else $error("vector later than three cycles");

	property p_no_early;
		@(posedge clk) disable iff (sys_rst || !ce)
		s_arm |=> !vec_r.take [*8];
	endproperty
	a_no_early: assert property (p_no_early) else $error("vector too early");

	property p_ext_flag;
		@(posedge clk) disable iff (sys_rst || !ce)
		(cfg_r[B_EDGE] ? ext_rise : ext_fall) |=> ctl_r[B_PIN_FLAG];
	endproperty
	a_ext_flag: assert property (p_ext_flag) else $error("external edge lost");

	property p_ext_polarity;
		@(posedge clk) disable iff (sys_rst || !ce)
		!cfg_r[B_EDGE] && ext_rise && !ctl_r[B_PIN_FLAG] && !wr_ctl |=> !ctl_r[B_PIN_FLAG];
	endproperty
	a_ext_polarity: assert property (p_ext_polarity) else $error("wrong edge accepted");

	property p_t0_flag;
		@(posedge clk) disable iff (sys_rst || !ce)
		$past(timer0_count) == T0_MAX && timer0_count == T0_MIN |=> ctl_r[B_T0_FLAG];
	endproperty
	a_t0_flag: assert property (p_t0_flag) else $error("timer rollover lost");

	property p_port_flag;
		@(posedge clk) disable iff (sys_rst || !ce)
		|(port_chg & pcm_r[PORT_W-1:0]) && !(port_read && ph_second) |=> ctl_r[B_CHG_FLAG];
	endproperty
	a_port_flag: assert property (p_port_flag) else $error("port change lost");

	property p_port_miss;
		@(posedge clk) disable iff (sys_rst || !ce)
		port_read && ph_second && !ctl_r[B_CHG_FLAG] && !wr_ctl |=> !ctl_r[B_CHG_FLAG];
	endproperty
	a_port_miss: assert property (p_port_miss) else $error("flag set in read window");

	property p_per_flag;
		@(posedge clk) disable iff (sys_rst || !ce)
		|per_evt |=> (pfl_r & $past(per_evt)) == $past(per_evt);
	endproperty
	a_per_flag: assert property (p_per_flag) else $error("peripheral event lost");

endmodule : irqc_top

// ---- test/irqc_core_model.sv ----
// Core model: takes the vector, counts nesting depth, returns on release.
// Assumes vec comes from irqc_top and release_ok from the bench.
`timescale 1ns/1ns
module irqc_core_model
	import irqc_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire irqc_vec_t vec,
	input wire logic release_ok,
	input wire logic slow,
	output logic return_from_handler,
	output logic [PC_W-1:0] pc_r,
	output logic [3:0] depth_r
);
	logic busy_r;
	logic [3:0] wait_r;

	// Only the jump target is kept; no other context is saved
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pc_r <= '0;
			depth_r <= 4'h0;
		end else if (vec.take) begin
			pc_r <= vec.addr;
			depth_r <= depth_r + 4'h1;
		end else if (return_from_handler) begin
			depth_r <= depth_r - 4'h1;
		end
	end

	// Prompt or slow return once the bench lets the handler finish
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_r <= 1'h0;
			wait_r <= 4'h0;
			return_from_handler <= 1'h0;
		end else begin
			return_from_handler <= 1'h0;
			if (vec.take) begin
				busy_r <= 1'h1;
				wait_r <= slow ? 4'h8 : 4'h1;
			end else if (busy_r && release_ok) begin
				if (wait_r == 4'h0) begin
					busy_r <= 1'h0;
					return_from_handler <= 1'h1;
				end else begin
					wait_r <= wait_r - 4'h1;
				end
			end
		end
	end
endmodule : irqc_core_model

// ---- test/tb.sv ----
// Self-checking bench for irqc_top with a core model on the vector side.
// Assumes the register map and latency of irqc_pkg.
`timescale 1ns/1ns
module tb;
	import irqc_pkg::*;
	typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} irqc_row_t;
	logic clk, sys_rst, ce, reg_wr, reg_rd, ext_pin, port_read, ret, irq_req, wake, release_ok, slow;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata_r, timer0_count, periph_evt;
	logic [5:0] port_pins;
	logic [PC_W-1:0] pc;
	logic [3:0] depth;
	irqc_vec_t vec_r;
	int cycles, failures, compares;
	irqc_row_t rows [11] = '{'{OFF_CTL, 8'h5B, 8'h5B}, '{OFF_PCM, 8'hFF, 8'h3F}, '{OFF_PFL, 8'hFF, 8'hFD},
		'{OFF_PEN, 8'hFF, 8'hFD}, '{OFF_CFG, 8'hFF, 8'h01}, '{3'h5, 8'hFF, 8'h00}, '{OFF_CTL, 8'h00, 8'h00},
		'{OFF_PCM, 8'h00, 8'h00}, '{OFF_PFL, 8'h00, 8'h00}, '{OFF_PEN, 8'h00, 8'h00}, '{OFF_CFG, 8'h00, 8'h00}};
	logic [7:0] tseq [4] = '{8'hFE, 8'hFF, 8'h00, 8'h01};

	irqc_top #(.PORT_W(6)) i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
		.external_interrupt_pin(ext_pin), .port_pins(port_pins), .port_read(port_read),
		.timer0_count(timer0_count), .periph_evt(periph_evt), .return_from_handler(ret),
		.irq_req(irq_req), .wake(wake), .vec_r(vec_r));
	irqc_core_model i_core (.clk(clk), .sys_rst(sys_rst), .vec(vec_r), .release_ok(release_ok), .slow(slow),
		.return_from_handler(ret), .pc_r(pc), .depth_r(depth));

	initial begin
		clk = 1'h0;
		forever #4 clk = ~clk;
	end

	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : complete_run

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			complete_run();
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rc(input logic [2:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1 chk(reg_rdata_r, exp);
	endtask : rc

	// Request and wake levels as {irq_req, wake}
	task automatic wk(input logic [7:0] exp);
		#1 chk(8'({irq_req, wake}), exp);
	endtask : wk

	task automatic no_take(input int n);
		logic t;
		t = 1'h0;
		repeat (n) begin
			@(posedge clk);
			#1 t = t | vec_r.take;
		end
		chk(8'(t), 8'h00);
	endtask : no_take

	// Waits for the vector, clears the flag, lets the core return
	task automatic service();
		int n;
		logic [3:0] d0;
		d0 = depth;
		for (n = 1; n < 20; n++) begin
			@(posedge clk);
			#1;
			if (vec_r.take === 1'h1) break;
		end
		chk(8'(n >= 13 && n <= 16), 8'h01);
		chk(8'({vec_r.addr === VECTOR, irq_req}), 8'h02);
		rc(OFF_CTL, 8'h24);
		chk(8'({pc === VECTOR, depth === d0 + 4'h1}), 8'h03);
		wr(OFF_CTL, 8'h20);
		@(posedge clk) release_ok <= 1'h1;
		for (n = 0; n < 20 && ret !== 1'h1; n++) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk) release_ok <= 1'h0;
		rc(OFF_CTL, 8'hA0);
		no_take(24);
		wr(OFF_CTL, 8'h00);
		$display("service done at %0t", $time);
	endtask : service

	initial begin
		int i, p, v;
		{sys_rst, ce} = 2'h3;
		{reg_wr, reg_rd, ext_pin, port_read, release_ok, slow} = 6'h00;
		{reg_addr, reg_wdata, timer0_count, periph_evt, port_pins} = '0;
		repeat (12) @(posedge clk);
		sys_rst <= 1'h0;
		for (i = 0; i < 8; i++) rc(3'(i), 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rc(rows[i].a, rows[i].e);
		end
		$display("register test done");
		for (p = 1; p >= 0; p--) begin
			wr(OFF_CFG, 8'(p));
			for (v = 1; v >= 0; v--) begin
				wr(OFF_CTL, 8'h00);
				@(posedge clk) ext_pin <= 1'(v);
				repeat (2) @(posedge clk);
				rc(OFF_CTL, (v == p) ? 8'h02 : 8'h00);
			end
		end
		wr(OFF_CTL, 8'h12);
		wk(8'h01);
		wr(OFF_CTL, 8'h02);
		wk(8'h00);
		wr(OFF_CTL, 8'h00);
		foreach (tseq[i]) @(posedge clk) timer0_count <= tseq[i];
		repeat (2) @(posedge clk);
		rc(OFF_CTL, 8'h04);
		wr(OFF_PCM, 8'h08);
		wr(OFF_CTL, 8'h00);
		@(posedge clk) port_pins <= 6'h01;
		repeat (2) @(posedge clk);
		rc(OFF_CTL, 8'h00);
		@(posedge clk) port_pins <= 6'h09;
		repeat (2) @(posedge clk);
		rc(OFF_CTL, 8'h01);
		// Change under a port read in the second phase is dropped
		wr(OFF_CTL, 8'h00);
		do @(posedge clk); while (i_dut.phase_r != PH_FIRST);
		port_pins <= 6'h01;
		port_read <= 1'h1;
		@(posedge clk) port_read <= 1'h0;
		repeat (2) @(posedge clk);
		rc(OFF_CTL, 8'h00);
		$display("event test done");
		wr(OFF_PEN, 8'h80);
		wr(OFF_CTL, 8'h40);
		@(posedge clk) periph_evt <= 8'h83;
		@(posedge clk) periph_evt <= 8'h00;
		rc(OFF_PFL, 8'h81);
		wk(8'h01);
		wr(OFF_PEN, 8'h00);
		wk(8'h00);
		wr(OFF_PFL, 8'h00);
		wr(OFF_CTL, 8'h00);
		$display("peripheral test done");
		for (p = 0; p < 2; p++) begin
			@(posedge clk) slow <= 1'(p);
			wr(OFF_CTL, 8'hA4);
			service();
		end
		wr(OFF_CTL, 8'hA4);
		wr(OFF_CTL, 8'h24);
		no_take(24);
		wk(8'h01);
		rc(OFF_CTL, 8'h24);
		wr(OFF_CTL, 8'hA4);
		service();
		wr(OFF_CTL, 8'h80);
		@(posedge clk) sys_rst <= 1'h1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'h0;
		rc(OFF_CTL, 8'h00);
		// Clock enable low: a write setting the global enable is ignored
		@(posedge clk) ce <= 1'h0;
		wr(OFF_CTL, 8'h80);
		@(posedge clk) ce <= 1'h1;
		rc(OFF_CTL, 8'h00);
		$display("reset test done");
		complete_run();
	end
endmodule : tb
